// >>> hw/srim_pkg.sv
// Constants, types and register map shared by both ends of the strobed register input link.
// Notes on behaviour
// - Eight 16-bit channels, one transferred per request.
// - Controller writes request word naming wanted channel.
// - Device returns channel data plus channel echo.
// - One output word, then echo and data inputs.
// - BCD mode 0000-9999, binary mode 0000-FFFF.
// - Shared data lines; strobe per channel addresses.
// - Strobes active low, high when unaddressed.
// - Strobe about 2 ms; sample no earlier than 180 us.
// - Field data held 100 us past sampling; a capture delayed by settling can come on the edge that releases the strobe.
// - No capture while field value is unsettled.
// - Polarity setting inverts data when active-low.
// - Format setting and map give BCD or binary.
// - Unstrobed field devices release the data lines.
// - Field change reaches input registers within 20 ms.
// - Map uses two input words, one output word.
package srim_pkg;
  localparam int unsigned      WORD_W       = 16;
  localparam int unsigned      NUM_CH       = 8;
  localparam int unsigned      CH_W         = 3;
  localparam int unsigned      CLK_KHZ      = 25000;
  localparam int unsigned      STROBE_US    = 2000;
  localparam int unsigned      SETUP_US     = 180;
  localparam int unsigned      HOLD_US      = 100;
  localparam int unsigned      STROBE_CYC   = (STROBE_US * CLK_KHZ) / 1000;
  localparam int unsigned      SETUP_CYC    = (SETUP_US * CLK_KHZ + 999) / 1000;
  localparam int unsigned      CNT_W        = 17;
  localparam logic [7:0]       STROBE_IDLE  = 8'hFF;
  localparam logic [15:0]      WORD_ZERO    = 16'h0000;
  localparam logic [3:0]       ADDR_CTRL    = 4'h0;
  localparam logic [3:0]       ADDR_REQUEST = 4'h1;
  localparam logic [3:0]       ADDR_ECHO    = 4'h2;
  localparam logic [3:0]       ADDR_DATA    = 4'h3;
  localparam logic [3:0]       ADDR_STATUS  = 4'h4;
  localparam int unsigned      CTRL_SCAN    = 0;
  localparam int unsigned      CTRL_MAP_BCD = 1;
  localparam int unsigned      STAT_BUSY    = 0;
  localparam int unsigned      STAT_DONE    = 1;
  typedef enum logic [1:0] {
    SRIM_IDLE   = 2'b00,
    SRIM_STROBE = 2'b01,
    SRIM_ANSWER = 2'b10
  } srim_state_t;
endpackage : srim_pkg

// >>> hw/srim_if.sv
// Backplane link between the controller end and the register input device end.
`timescale 1ns/1ns
interface srim_if;
  logic        req_valid;
  logic [15:0] req_word;
  logic        ack;
  logic [15:0] echo_word;
  logic [15:0] data_word;
  modport dev  (input req_valid, input req_word, output ack, output echo_word, output data_word);
  modport ctrl (output req_valid, output req_word, input ack, input echo_word, input data_word);
endinterface : srim_if

// >>> hw/srim_device.sv
// Device end: strobes one field channel per request and returns echo and data words.
//
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/1ns
module srim_device #(
  parameter int unsigned STROBE_CYC = srim_pkg::STROBE_CYC,
  parameter int unsigned SETUP_CYC  = srim_pkg::SETUP_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  srim_if.dev              link,
  input  wire logic [15:0] field_data,
  input  wire logic [7:0]  field_value_unsettled,
  input  wire logic        polarity_low,
  input  wire logic        format_bcd,
  output logic      [7:0]  field_strobe_n,
  output logic             format_bcd_out
);

  function automatic logic chan_ok(input logic [15:0] w);
    chan_ok = (w < 16'(srim_pkg::NUM_CH));
  endfunction : chan_ok

  srim_pkg::srim_state_t    state_q,   state_d;
  logic [srim_pkg::CNT_W-1:0] cnt_q,   cnt_d;
  logic [srim_pkg::CH_W-1:0]  ch_q,    ch_d;
  logic                     got_q,     got_d;
  logic [15:0]              hold_q,    hold_d;
  logic [7:0]               strobe_n_q, strobe_n_d;
  logic                     ack_q,     ack_d;
  logic [15:0]              echo_q,    echo_d;
  logic [15:0]              data_q,    data_d;
  logic                     fmt_q,     fmt_d;
  logic [15:0]              sample;

  // Inversion is applied at capture so both formats see the same true-high word.
  assign sample = polarity_low ? ~field_data : field_data;

  always_comb begin
    state_d    = state_q;
    cnt_d      = cnt_q;
    ch_d       = ch_q;
    got_d      = got_q;
    hold_d     = hold_q;
    strobe_n_d = strobe_n_q;
    ack_d      = 1'b0;
    echo_d     = echo_q;
    data_d     = data_q;
    fmt_d      = format_bcd;
    case (state_q)
      srim_pkg::SRIM_IDLE: begin
        strobe_n_d = srim_pkg::STROBE_IDLE;
        if (link.req_valid) begin
          if (chan_ok(link.req_word)) begin
            ch_d       = link.req_word[srim_pkg::CH_W-1:0];
            strobe_n_d = ~(8'h01 << link.req_word[srim_pkg::CH_W-1:0]);
            cnt_d      = '0;
            got_d      = 1'b0;
            state_d    = srim_pkg::SRIM_STROBE;
          end else begin
            state_d = srim_pkg::SRIM_ANSWER;
            got_d   = 1'b0;
          end
        end
      end
      srim_pkg::SRIM_STROBE: begin
        cnt_d = cnt_q + 1'b1;
        // Sampling waits for the setup time, then for the field device to report a settled value.
        if (!got_q && (cnt_q >= srim_pkg::CNT_W'(SETUP_CYC - 1)) &&
            !field_value_unsettled[ch_q]) begin
          got_d  = 1'b1;
          hold_d = sample;
        end
        if (cnt_q >= srim_pkg::CNT_W'(STROBE_CYC - 1)) begin
          strobe_n_d = srim_pkg::STROBE_IDLE;
          state_d    = srim_pkg::SRIM_ANSWER;
        end
      end
      srim_pkg::SRIM_ANSWER: begin
        ack_d   = 1'b1;
        state_d = srim_pkg::SRIM_IDLE;
        // Both words move in one edge so software never pairs a stale echo with fresh data.
        if (got_q) begin
          echo_d = {13'h0000, ch_q};
          data_d = hold_q;
        end
      end
      default: begin
        state_d    = srim_pkg::SRIM_IDLE;
        strobe_n_d = srim_pkg::STROBE_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q    <= srim_pkg::SRIM_IDLE;
      cnt_q      <= '0;
      ch_q       <= '0;
      got_q      <= 1'b0;
      hold_q     <= srim_pkg::WORD_ZERO;
      strobe_n_q <= srim_pkg::STROBE_IDLE;
      ack_q      <= 1'b0;
      echo_q     <= srim_pkg::WORD_ZERO;
      data_q     <= srim_pkg::WORD_ZERO;
      fmt_q      <= 1'b0;
    end else begin
      state_q    <= state_d;
      cnt_q      <= cnt_d;
      ch_q       <= ch_d;
      got_q      <= got_d;
      hold_q     <= hold_d;
      strobe_n_q <= strobe_n_d;
      ack_q      <= ack_d;
      echo_q     <= echo_d;
      data_q     <= data_d;
      fmt_q      <= fmt_d;
    end
  end

  assign field_strobe_n = strobe_n_q;
  assign format_bcd_out = fmt_q;
  assign link.ack       = ack_q;
  assign link.echo_word = echo_q;
  assign link.data_word = data_q;

endmodule : srim_device

// >>> hw/srim_ctrl.sv
// Controller end: software register port, request issue, round-robin scan and number mapping.
`timescale 1ns/1ns
module srim_ctrl (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  srim_if.ctrl             link,
  input  wire logic [3:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [15:0] rdata
);

  // Binary to four BCD digits; values above 9999 lose their top digit.
  function automatic logic [15:0] bin2bcd(input logic [15:0] b);
    logic [19:0] d;
    d = '0;
    for (int i = 15; i >= 0; i--) begin
      for (int k = 0; k < 5; k++) begin
        if (d[k*4 +: 4] > 4'h4) d[k*4 +: 4] = d[k*4 +: 4] + 4'h3;
      end
      d = {d[18:0], b[i]};
    end
    bin2bcd = d[15:0];
  endfunction : bin2bcd

  logic [1:0]  ctrl_q,  ctrl_d;
  logic        busy_q,  busy_d;
  logic        done_q,  done_d;
  logic        req_q,   req_d;
  logic [15:0] word_q,  word_d;
  logic [2:0]  next_q,  next_d;
  logic [15:0] rdata_q, rdata_d;
  logic [15:0] mapped;

  // Under BCD mapping the incoming word is converted; a BCD switch setting then gives garbage.
  assign mapped = ctrl_q[srim_pkg::CTRL_MAP_BCD] ? bin2bcd(link.data_word) : link.data_word;

  always_comb begin
    ctrl_d  = ctrl_q;
    busy_d  = busy_q;
    done_d  = done_q;
    req_d   = 1'b0;
    word_d  = word_q;
    next_d  = next_q;
    rdata_d = srim_pkg::WORD_ZERO;
    if (wr && addr == srim_pkg::ADDR_CTRL) ctrl_d = wdata[1:0];
    if (wr && addr == srim_pkg::ADDR_REQUEST) done_d = 1'b0;
    if (!busy_q) begin
      if (wr && addr == srim_pkg::ADDR_REQUEST) begin
        req_d  = 1'b1;
        word_d = wdata;
        busy_d = 1'b1;
      end else if (ctrl_q[srim_pkg::CTRL_SCAN]) begin
        // Eight 2 ms strobes in turn revisit each channel well inside 20 ms.
        req_d  = 1'b1;
        word_d = {13'h0000, next_q};
        next_d = next_q + 3'h1;
        busy_d = 1'b1;
      end
    end
    if (link.ack) begin
      busy_d = 1'b0;
      done_d = 1'b1;
    end
    if (rd) begin
      case (addr)
        srim_pkg::ADDR_CTRL:    rdata_d = {14'h0000, ctrl_q};
        srim_pkg::ADDR_REQUEST: rdata_d = word_q;
        srim_pkg::ADDR_ECHO:    rdata_d = link.echo_word;
        srim_pkg::ADDR_DATA:    rdata_d = mapped;
        srim_pkg::ADDR_STATUS:  rdata_d = {14'h0000, done_q, busy_q};
        default:                rdata_d = srim_pkg::WORD_ZERO;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_q  <= 2'h0;
      busy_q  <= 1'b0;
      done_q  <= 1'b0;
      req_q   <= 1'b0;
      word_q  <= srim_pkg::WORD_ZERO;
      next_q  <= 3'h0;
      rdata_q <= srim_pkg::WORD_ZERO;
    end else begin
      ctrl_q  <= ctrl_d;
      busy_q  <= busy_d;
      done_q  <= done_d;
      req_q   <= req_d;
      word_q  <= word_d;
      next_q  <= next_d;
      rdata_q <= rdata_d;
    end
  end

  assign link.req_valid = req_q;
  assign link.req_word  = word_q;
  assign rdata          = rdata_q;

endmodule : srim_ctrl

// >>> verification/srim_props.sv
// Concurrent checks on the link between the controller end and the device end.
`timescale 1ns/1ns
module srim_props #(
  parameter int unsigned STROBE_CYC = 40
) (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        req_valid,
  input wire logic [15:0] req_word,
  input wire logic        ack,
  input wire logic [15:0] echo_word,
  input wire logic [15:0] data_word,
  input wire logic [7:0]  field_strobe_n
);
  localparam int SW1 = STROBE_CYC - 1;
  localparam int AD  = STROBE_CYC + 2;
  logic ok_ch;
  logic bad_ch;
  assign ok_ch  = req_valid && (req_word < 16'h0008);
  assign bad_ch = req_valid && (req_word >= 16'h0008);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_strobe_onehot: assert property ($onehot0(~field_strobe_n)) else $error("two strobes low");
  a_reset_idle: assert property (disable iff (1'b0) rst |=> &field_strobe_n && !ack)
    else $error("strobe or ack active after reset");
  a_strobe_select: assert property (ok_ch |=> field_strobe_n == ~(8'h01 << req_word[2:0]))
    else $error("wrong strobe");
  a_strobe_width: assert property ($fell(&field_strobe_n) |-> ##SW1 !(&field_strobe_n) ##1 &field_strobe_n)
    else $error("strobe width wrong");
  a_ack_delay: assert property (ok_ch |-> ##AD ack) else $error("ack late");
  a_invalid_quiet: assert property (bad_ch |=> &field_strobe_n ##1 (ack && &field_strobe_n && $stable(echo_word)
    && $stable(data_word))) else $error("invalid channel acted");
  a_words_paired: assert property (($changed(echo_word) || $changed(data_word)) |-> ack)
    else $error("words changed without ack");
  a_echo_value: assert property ($changed(echo_word) |-> echo_word == {13'h0000, req_word[2:0]})
    else $error("echo wrong");
  a_ack_pulse: assert property (ack |=> !ack) else $error("ack too long");
  cover property (ok_ch ##AD ack);
  cover property (bad_ch ##2 ack);
  cover property ($changed(data_word));
  cover property (ack && echo_word == 16'h0005);
endmodule : srim_props

// >>> verification/srim_test.sv
// Self-checking bench joining both ends of the strobed register input link.
`timescale 1ns/1ns
module srim_test;
  logic        sys_clk    = 1'b0;
  logic        rst        = 1'b1;
  logic [3:0]  addr       = 4'h0;
  logic [15:0] wdata      = 16'h0000;
  logic        wr         = 1'b0;
  logic        rd         = 1'b0;
  logic [15:0] field_data = 16'h0000;
  logic [7:0]  unsettled  = 8'h00;
  logic        pol        = 1'b0;
  logic        fmt        = 1'b0;
  logic [15:0] rdata, v, nx, exp_w;
  logic [7:0]  strobe_n;
  logic        fmt_out, p;
  logic [15:0] fd [8];
  int          n_fail, comparisons, cyc;
  srim_if link ();
  srim_device #(.STROBE_CYC(40), .SETUP_CYC(10)) srim_device_inst (.sys_clk(sys_clk), .rst(rst), .link(link),
    .field_data(field_data), .field_value_unsettled(unsettled), .polarity_low(pol), .format_bcd(fmt),
    .field_strobe_n(strobe_n), .format_bcd_out(fmt_out));
  srim_ctrl srim_ctrl_inst (.sys_clk(sys_clk), .rst(rst), .link(link), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata));
  srim_props #(.STROBE_CYC(40)) srim_props_inst (.sys_clk(sys_clk), .rst(rst), .req_valid(link.req_valid),
    .req_word(link.req_word), .ack(link.ack), .echo_word(link.echo_word), .data_word(link.data_word),
    .field_strobe_n(strobe_n));
  initial begin
    forever #20 sys_clk = ~sys_clk;
  end
  // Unstrobed lines float, so the field side shows a toggling pattern rather than stale data.
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    nx = ~field_data;
    for (int i = 0; i < 8; i++) if (!strobe_n[i]) nx = fd[i];
    field_data <= nx;
    if (cyc == 20000) begin
      n_fail++;
      finish_test();
    end
  end
  function automatic logic [15:0] bcd(input logic [15:0] b);
    return {4'(b / 1000), 4'(b / 100 % 10), 4'(b / 10 % 10), 4'(b % 10)};
  endfunction : bcd
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    @(negedge sys_clk);
    d = rdata;
  endtask : rd_reg
  task automatic xfer(input logic [15:0] ch, input logic [15:0] e_echo, input logic [15:0] e_data);
    wr_reg(srim_pkg::ADDR_REQUEST, ch);
    v = 16'h0000;
    for (int k = 0; k < 40 && v[srim_pkg::STAT_DONE] !== 1'b1; k++) rd_reg(srim_pkg::ADDR_STATUS, v);
    chk(v, 16'h0002);
    rd_reg(srim_pkg::ADDR_ECHO, v);
    chk(v, e_echo);
    rd_reg(srim_pkg::ADDR_DATA, v);
    chk(v, e_data);
  endtask : xfer
  task automatic finish_test();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test
  initial begin
    void'($urandom(32'hC4CF));
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    for (int a = 0; a < 5; a++) begin
      rd_reg(4'(a), v);
      chk(v, 16'h0000);
    end
    rd_reg(4'hF, v);
    chk(v, 16'h0000);
    for (int c = 0; c < 8; c++) begin
      fd[c] = (c == 7) ? 16'hFFFF : 16'($urandom());
      p = 1'($urandom());
      @(posedge sys_clk);
      pol <= p;
      fmt <= ~p;
      exp_w = p ? ~fd[c] : fd[c];
      xfer(16'(c), 16'(c), exp_w);
      chk({15'h0000, fmt_out}, {15'h0000, ~p});
    end
    xfer(16'h0008, 16'h0007, exp_w);
    @(posedge sys_clk);
    unsettled <= 8'h08;
    fd[3] = 16'h1234;
    xfer(16'h0003, 16'h0007, exp_w);
    @(posedge sys_clk);
    unsettled <= 8'h00;
    pol <= 1'b0;
    fmt <= 1'b0;
    xfer(16'h0003, 16'h0003, 16'h1234);
    wr_reg(srim_pkg::ADDR_CTRL, 16'h0002);
    rd_reg(srim_pkg::ADDR_CTRL, v);
    chk(v, 16'h0002);
    fd[2] = 16'($urandom() % 10000);
    xfer(16'h0002, 16'h0002, bcd(fd[2]));
    // Scan mode must pick up a field change on channel five within one round of all channels.
    fd[5] = 16'($urandom());
    wr_reg(srim_pkg::ADDR_CTRL, 16'h0001);
    for (int r = 0; r < 2; r++) begin
      v = 16'h0005;
      for (int k = 0; k < 50 && v === 16'h0005; k++) rd_reg(srim_pkg::ADDR_ECHO, v);
      for (int k = 0; k < 250 && v !== 16'h0005; k++) rd_reg(srim_pkg::ADDR_ECHO, v);
      chk(v, 16'h0005);
      rd_reg(srim_pkg::ADDR_DATA, v);
      chk(v, fd[5]);
      fd[5] = ~fd[5];
    end
    finish_test();
  end
endmodule : srim_test
